// >>> hdl/ptc_event_edge.sv
// synchroniser and edge qualifier for one event input
`timescale 1ns/1ps
module ptc_event_edge (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // event
    input wire logic event_in,
    input wire logic edge_fall,
    // qualified result
    output logic level,
    output logic rise,
    output logic fall,
    output logic active_edge
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= event_in;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level = sync;
    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
    // one pulse per qualifying transition
    assign active_edge = edge_fall ? fall : rise;
endmodule : ptc_event_edge

// >>> hdl/ptc_map.svh
// register offsets, field positions, reset values and timing counts for the timer block
`ifndef PTC_MAP_SVH
`define PTC_MAP_SVH

`define PTC_OFF_NARROW_VALUE 12'h000
`define PTC_OFF_WIDE_LOW 12'h004
`define PTC_OFF_WIDE_HIGH 12'h008
`define PTC_OFF_NARROW_CTRL 12'h00C
`define PTC_OFF_WIDE_CTRL 12'h010
`define PTC_OFF_INT_CTRL 12'h014
`define PTC_OFF_STATUS 12'h018

`define PTC_MODE_HI 7
`define PTC_MODE_LO 6
`define PTC_SRC_BIT 5
`define PTC_RUN_BIT 4
`define PTC_EDGE_BIT 3
`define PTC_PSC_HI 2

`define PTC_NARROW_CTRL_RST 8'h08
`define PTC_WIDE_CTRL_RST 8'h08
`define PTC_NARROW_CTRL_MASK 8'hDF
`define PTC_WIDE_CTRL_MASK 8'hF8

`define PTC_SYS_QUARTER 4

`endif

// >>> hdl/ptc_pkg.sv
// types shared by the timer block
package ptc_pkg;

    typedef enum logic [1:0] {
        PTC_MODE_CMP = 2'b00,
        PTC_MODE_PIN = 2'b01,
        PTC_MODE_TIMER = 2'b10,
        PTC_MODE_PULSE = 2'b11
    } ptc_mode_e;

    typedef struct packed {
        ptc_mode_e mode;
        logic clk_src;
        logic run;
        logic edge_fall;
        logic [2:0] psc;
    } ptc_ctrl_s;

    typedef struct packed {
        logic narrow_ovf;
        logic wide_ovf;
    } ptc_events_s;

endpackage : ptc_pkg

// >>> hdl/ptc_prescaler.sv
// free running prescaler giving a one-cycle tick at pclk divided by two to the code
`timescale 1ns/1ps
module ptc_prescaler #(
    parameter int WIDTH = 7
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // ratio code
    input wire logic [2:0] code,
    // tick
    output logic tick
);
    if (WIDTH < 7) begin : g_width_check
        $error("prescaler needs at least 7 bits");
    end

    logic [WIDTH-1:0] count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) count <= '0;
        else count <= count + 1'b1;
    end

    function automatic logic [WIDTH-1:0] low_mask(input logic [2:0] c);
        logic [WIDTH-1:0] m;
        m = '0;
        for (int i = 0; i < WIDTH; i++) m[i] = (i < int'(c));
        return m;
    endfunction : low_mask

    // divide by one gives a tick every cycle
    assign tick = ((count & low_mask(code)) == '0);
endmodule : ptc_prescaler

// >>> hdl/ptc_timers.sv
// two preloaded timer event counters with apb registers
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ptc_map.svh"
module ptc_timers
    import ptc_pkg::*;
#(
    parameter int NARROW_W = 8,
    parameter int WIDE_W = 16
) (
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // event sources and sub clock tick
    input wire logic narrow_event_pin,
    input wire logic wide_event_pin,
    input wire logic first_comparator_output,
    input wire logic second_comparator_output,
    input wire logic sub_clock,
    input wire logic power_down,
    // interrupt requests to the processor
    output logic narrow_irq,
    output logic wide_irq,
    output logic wake_up
);
    if (NARROW_W != 8 || WIDE_W != 16) begin : g_width_check
        $error("byte-wide register map needs 8 and 16 bits");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register bus
    logic [7:0] narrow_counter_value;
    logic [7:0] narrow_preload;
    logic [7:0] wide_low;
    logic [7:0] wide_high;
    logic [7:0] wide_preload_low;
    logic [7:0] wide_preload_high;
    logic [7:0] wide_low_stage;
    logic [7:0] wide_low_latch;
    ptc_ctrl_s narrow_counter_control;
    ptc_ctrl_s wide_counter_control;
    logic [1:0] interrupt_control_reg;
    ptc_events_s ovf_flags;

    logic wr_en;
    logic rd_en;
    logic addr_ok;
    assign addr_ok = (paddr == `PTC_OFF_NARROW_VALUE) || (paddr == `PTC_OFF_WIDE_LOW) ||
                     (paddr == `PTC_OFF_WIDE_HIGH) || (paddr == `PTC_OFF_NARROW_CTRL) ||
                     (paddr == `PTC_OFF_WIDE_CTRL) || (paddr == `PTC_OFF_INT_CTRL) ||
                     (paddr == `PTC_OFF_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en = psel & penable & pwrite & addr_ok;
    // read side acts in the setup cycle so the low latch matches the captured high byte
    assign rd_en = psel & ~penable & ~pwrite & addr_ok;

    function automatic logic is_wr(input logic en, input logic [11:0] a, input logic [11:0] off);
        return en && (a == off);
    endfunction : is_wr

    logic wr_narrow_val;
    logic wr_wide_low;
    logic wr_wide_high;
    logic rd_wide_high;
    assign wr_narrow_val = is_wr(wr_en, paddr, `PTC_OFF_NARROW_VALUE);
    assign wr_wide_low = is_wr(wr_en, paddr, `PTC_OFF_WIDE_LOW);
    assign wr_wide_high = is_wr(wr_en, paddr, `PTC_OFF_WIDE_HIGH);
    assign rd_wide_high = is_wr(rd_en, paddr, `PTC_OFF_WIDE_HIGH);

    ////////////////////////////////////////////////////////////////////////////////
    // event sources
    logic n_pin_level, n_pin_edge, n_pin_rise, n_pin_fall;
    logic n_cmp_edge;
    logic w_pin_level, w_pin_edge, w_pin_rise, w_pin_fall;
    logic w_cmp_edge;
    logic sub_tick;

    ptc_event_edge u_n_pin (.pclk(pclk), .presetn(presetn), .event_in(narrow_event_pin),
        .edge_fall(narrow_counter_control.edge_fall), .level(n_pin_level),
        .rise(n_pin_rise), .fall(n_pin_fall), .active_edge(n_pin_edge));
    ptc_event_edge u_n_cmp (.pclk(pclk), .presetn(presetn), .event_in(first_comparator_output),
        .edge_fall(narrow_counter_control.edge_fall), .level(), .rise(), .fall(),
        .active_edge(n_cmp_edge));
    ptc_event_edge u_w_pin (.pclk(pclk), .presetn(presetn), .event_in(wide_event_pin),
        .edge_fall(wide_counter_control.edge_fall), .level(w_pin_level),
        .rise(w_pin_rise), .fall(w_pin_fall), .active_edge(w_pin_edge));
    ptc_event_edge u_w_cmp (.pclk(pclk), .presetn(presetn), .event_in(second_comparator_output),
        .edge_fall(wide_counter_control.edge_fall), .level(), .rise(), .fall(),
        .active_edge(w_cmp_edge));
    ptc_event_edge u_sub (.pclk(pclk), .presetn(presetn), .event_in(sub_clock),
        .edge_fall(1'b0), .level(), .rise(), .fall(), .active_edge(sub_tick));

    logic psc_tick;
    ptc_prescaler #(.WIDTH(7)) u_psc (.pclk(pclk), .presetn(presetn),
        .code(narrow_counter_control.psc), .tick(psc_tick));

    logic [1:0] quarter_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) quarter_cnt <= 2'h0;
        else quarter_cnt <= quarter_cnt + 2'h1;
    end
    logic quarter_tick;
    assign quarter_tick = (quarter_cnt == 2'(`PTC_SYS_QUARTER - 1));

    ////////////////////////////////////////////////////////////////////////////////
    // count enables per mode
    logic n_pulse_active;
    logic w_pulse_active;
    logic n_step;
    logic w_step;
    logic w_int_tick;
    assign w_int_tick = wide_counter_control.clk_src ? sub_tick : quarter_tick;

    always_comb begin
        n_step = 1'b0;
        case (narrow_counter_control.mode)
            PTC_MODE_CMP: n_step = n_cmp_edge;
            PTC_MODE_PIN: n_step = n_pin_edge;
            PTC_MODE_TIMER: n_step = psc_tick;
            PTC_MODE_PULSE: n_step = psc_tick & n_pulse_active;
            default: n_step = 1'b0;
        endcase
        n_step = n_step & narrow_counter_control.run;
    end

    always_comb begin
        w_step = 1'b0;
        case (wide_counter_control.mode)
            PTC_MODE_CMP: w_step = w_cmp_edge;
            PTC_MODE_PIN: w_step = w_pin_edge;
            PTC_MODE_TIMER: w_step = w_int_tick;
            PTC_MODE_PULSE: w_step = w_int_tick & w_pulse_active;
            default: w_step = 1'b0;
        endcase
        w_step = w_step & wide_counter_control.run;
    end

    // pulse width: start on the edge opposite the selected one, stop and clear run on the selected edge
    logic n_pulse_end;
    logic w_pulse_end;
    assign n_pulse_end = n_pulse_active &
        (narrow_counter_control.edge_fall ? n_pin_fall : n_pin_rise);
    assign w_pulse_end = w_pulse_active &
        (wide_counter_control.edge_fall ? w_pin_fall : w_pin_rise);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_pulse_active <= 1'b0;
            w_pulse_active <= 1'b0;
        end else begin
            if (narrow_counter_control.mode != PTC_MODE_PULSE || !narrow_counter_control.run)
                n_pulse_active <= 1'b0;
            else if (n_pulse_end) n_pulse_active <= 1'b0;
            else if (narrow_counter_control.edge_fall ? n_pin_rise : n_pin_fall)
                n_pulse_active <= 1'b1;
            if (wide_counter_control.mode != PTC_MODE_PULSE || !wide_counter_control.run)
                w_pulse_active <= 1'b0;
            else if (w_pulse_end) w_pulse_active <= 1'b0;
            else if (wide_counter_control.edge_fall ? w_pin_rise : w_pin_fall)
                w_pulse_active <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            narrow_counter_control <= ptc_ctrl_s'(`PTC_NARROW_CTRL_RST);
            wide_counter_control <= ptc_ctrl_s'(`PTC_WIDE_CTRL_RST);
            interrupt_control_reg <= 2'h0;
        end else begin
            if (is_wr(wr_en, paddr, `PTC_OFF_NARROW_CTRL))
                narrow_counter_control <= ptc_ctrl_s'(pwdata[7:0] & `PTC_NARROW_CTRL_MASK);
            else if (n_pulse_end) narrow_counter_control.run <= 1'b0;
            if (is_wr(wr_en, paddr, `PTC_OFF_WIDE_CTRL))
                wide_counter_control <= ptc_ctrl_s'(pwdata[7:0] & `PTC_WIDE_CTRL_MASK);
            else if (w_pulse_end) wide_counter_control.run <= 1'b0;
            if (is_wr(wr_en, paddr, `PTC_OFF_INT_CTRL)) interrupt_control_reg <= pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // preload registers carry no reset value
    always_ff @(posedge pclk) begin
        if (wr_narrow_val) narrow_preload <= pwdata[7:0];
        if (wr_wide_low) wide_low_stage <= pwdata[7:0];
        if (wr_wide_high) begin
            wide_preload_high <= pwdata[7:0];
            wide_preload_low <= wide_low_stage;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counters
    logic n_ovf;
    logic w_ovf;
    assign n_ovf = n_step && (narrow_counter_value == 8'hFF);
    assign w_ovf = w_step && ({wide_high, wide_low} == 16'hFFFF);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) narrow_counter_value <= 8'h00;
        else if (wr_narrow_val && !narrow_counter_control.run)
            narrow_counter_value <= pwdata[7:0];
        else if (n_ovf) narrow_counter_value <= narrow_preload;
        else if (n_step) narrow_counter_value <= narrow_counter_value + 8'h01;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wide_high <= 8'h00;
            wide_low <= 8'h00;
        end else if (wr_wide_high && !wide_counter_control.run) begin
            wide_high <= pwdata[7:0];
            wide_low <= wide_low_stage;
        end else if (w_ovf) begin
            {wide_high, wide_low} <= {wide_preload_high, wide_preload_low};
        end else if (w_step) begin
            {wide_high, wide_low} <= {wide_high, wide_low} + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wide_low_latch <= 8'h00;
        else if (rd_wide_high) wide_low_latch <= wide_low;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt requests and wake-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ovf_flags <= '0;
        else begin
            ovf_flags.narrow_ovf <= n_ovf;
            ovf_flags.wide_ovf <= w_ovf;
        end
    end
    assign narrow_irq = ovf_flags.narrow_ovf & interrupt_control_reg[0];
    assign wide_irq = ovf_flags.wide_ovf & interrupt_control_reg[1];
    // counting ignores power_down, so an enabled overflow wakes the processor
    assign wake_up = power_down & (narrow_irq | wide_irq);

    ////////////////////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) begin
            case (paddr)
                `PTC_OFF_NARROW_VALUE: prdata <= {24'h0, narrow_counter_value};
                `PTC_OFF_WIDE_LOW: prdata <= {24'h0, wide_low_latch};
                `PTC_OFF_WIDE_HIGH: prdata <= {24'h0, wide_high};
                `PTC_OFF_NARROW_CTRL: prdata <= {24'h0, 8'(narrow_counter_control)};
                `PTC_OFF_WIDE_CTRL: prdata <= {24'h0, 8'(wide_counter_control)};
                `PTC_OFF_INT_CTRL: prdata <= {30'h0, interrupt_control_reg};
                `PTC_OFF_STATUS: prdata <= {28'h0, w_pulse_active, n_pulse_active,
                    w_pin_level, n_pin_level};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    chk_narrow_reload: assert property (@(posedge pclk) disable iff (!presetn)
        n_ovf && !wr_narrow_val |=> narrow_counter_value == $past(narrow_preload))
        else $error("narrow counter did not reload on overflow");
    chk_narrow_step: assert property (@(posedge pclk) disable iff (!presetn)
        n_step && !n_ovf && !wr_narrow_val |=>
            narrow_counter_value == $past(narrow_counter_value) + 8'h01)
        else $error("narrow counter did not advance by one");
    chk_narrow_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !narrow_counter_control.run && !wr_narrow_val |=> $stable(narrow_counter_value))
        else $error("stopped narrow counter moved");
    chk_stopped_load: assert property (@(posedge pclk) disable iff (!presetn)
        wr_narrow_val && !narrow_counter_control.run |=>
            narrow_counter_value == $past(pwdata[7:0]))
        else $error("stopped preload write did not reach counter");
    chk_running_load: assert property (@(posedge pclk) disable iff (!presetn)
        wr_narrow_val && narrow_counter_control.run && !n_step |=> $stable(narrow_counter_value))
        else $error("running preload write changed counter");
    chk_low_stage: assert property (@(posedge pclk) disable iff (!presetn)
        wr_wide_low && !w_step |=> $stable(wide_low))
        else $error("low byte write changed live count");
    chk_high_pair: assert property (@(posedge pclk) disable iff (!presetn)
        wr_wide_high && !wide_counter_control.run |=> wide_low == $past(wide_low_stage))
        else $error("high byte write did not move staged low byte");
    chk_low_latch: assert property (@(posedge pclk) disable iff (!presetn)
        rd_wide_high |=> wide_low_latch == $past(wide_low))
        else $error("high byte read did not latch low byte");
    chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        n_ovf ##1 interrupt_control_reg[0] |-> narrow_irq)
        else $error("enabled overflow gave no interrupt");
    chk_wide_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        w_step && {wide_high, wide_low} == 16'hFFFF && !wr_wide_high |=> ovf_flags.wide_ovf)
        else $error("wide overflow not flagged");
    chk_wide_reload: assert property (@(posedge pclk) disable iff (!presetn)
        w_ovf && !wr_wide_high |=>
            {wide_high, wide_low} == $past({wide_preload_high, wide_preload_low}))
        else $error("wide counter did not reload on overflow");
    chk_wide_step: assert property (@(posedge pclk) disable iff (!presetn)
        w_step && !w_ovf |=> {wide_high, wide_low} == $past({wide_high, wide_low}) + 16'h0001)
        else $error("wide counter did not advance by one");
    chk_narrow_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        n_step && narrow_counter_value == 8'hFF |=> ovf_flags.narrow_ovf)
        else $error("narrow overflow not flagged");
    chk_wide_irq: assert property (@(posedge pclk) disable iff (!presetn)
        w_ovf ##1 interrupt_control_reg[1] |-> wide_irq)
        else $error("enabled wide overflow gave no interrupt");
    chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
        !interrupt_control_reg[0] && !interrupt_control_reg[1] |-> !narrow_irq && !wide_irq)
        else $error("masked overflow reached the processor");
    chk_pulse_stop: assert property (@(posedge pclk) disable iff (!presetn)
        n_pulse_end && !wr_en |=> !narrow_counter_control.run)
        else $error("pulse end did not clear run");
    chk_event_bypass: assert property (@(posedge pclk) disable iff (!presetn)
        narrow_counter_control.mode == PTC_MODE_PIN |->
            n_step == (n_pin_edge && narrow_counter_control.run))
        else $error("pin event count went through the prescaler");
    chk_wide_source: assert property (@(posedge pclk) disable iff (!presetn)
        wide_counter_control.mode == PTC_MODE_TIMER && wide_counter_control.run |->
            w_step == (wide_counter_control.clk_src ? sub_tick : quarter_tick))
        else $error("wide timer ignored its clock source");
    chk_wake_path: assert property (@(posedge pclk) disable iff (!presetn)
        power_down && (narrow_irq || wide_irq) |-> wake_up)
        else $error("overflow in power-down gave no wake-up");
endmodule : ptc_timers

// >>> verification/ptc_event_src.sv
// event source model: comparator outputs, timer pins and sub clock
`timescale 1ns/1ps
module ptc_event_src (
    // clock
    input wire logic pclk,
    // event lines
    output logic narrow_event_pin,
    output logic wide_event_pin,
    output logic first_comparator_output,
    output logic second_comparator_output,
    output logic sub_clock
);
    logic [4:0] lines = 5'h00;
    assign {second_comparator_output, first_comparator_output} = lines[3:2];
    assign {wide_event_pin, narrow_event_pin} = lines[1:0];
    assign sub_clock = lines[4];
    ////////////////////////////////////////////////////////////////////////
    // high 4 cycles, low 7 between pulses, so the synchroniser sees every edge
    task automatic pulse(input int sel, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            lines[sel] <= 1'b1;
            repeat (4) @(posedge pclk);
            lines[sel] <= 1'b0;
            repeat (6) @(posedge pclk);
        end
    endtask : pulse
endmodule : ptc_event_src

// >>> verification/tb_top.sv
// self-checking bench for the timer block
`timescale 1ns/1ps
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic power_down = 1'b0;
    logic ne, we, c1, c2, sc, nirq, wirq, wake;
    int bad_count = 0, num_checks = 0, cyc = 0, n_irq = 0, w_irq = 0, n_wake = 0, last_irq = 0;
    int w_last = 0;

    initial forever #12.5 pclk = ~pclk;

    ptc_timers ptc_timers_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .narrow_event_pin(ne),
        .wide_event_pin(we), .first_comparator_output(c1), .second_comparator_output(c2),
        .sub_clock(sc), .power_down(power_down), .narrow_irq(nirq), .wide_irq(wirq),
        .wake_up(wake));
    ptc_event_src ptc_event_src_inst (.pclk(pclk), .narrow_event_pin(ne),
        .wide_event_pin(we), .first_comparator_output(c1),
        .second_comparator_output(c2), .sub_clock(sc));

    // irq lines are one-cycle pulses, so count them as they pass
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (nirq === 1'b1) begin
            n_irq <= n_irq + 1;
            last_irq <= cyc;
        end
        if (wirq === 1'b1) begin
            w_irq <= w_irq + 1;
            w_last <= cyc;
        end
        if (wake === 1'b1) n_wake <= n_wake + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            bad_count++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rdc

    task automatic wait_irq(input int target);
        int n;
        for (n = 0; n < 600 && n_irq < target; n++) @(posedge pclk);
        if (n >= 600) begin
            bad_count++;
            report_and_stop();
        end
    endtask : wait_irq

    task automatic wait_wide(input int target);
        int n;
        for (n = 0; n < 600 && w_irq < target; n++) @(posedge pclk);
        if (n >= 600) begin
            bad_count++;
            report_and_stop();
        end
    endtask : wait_wide
    ////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        rdc("narrow ctrl reset", 12'h00C, 32'h0000_0008);
        rdc("wide ctrl reset", 12'h010, 32'h0000_0008);
        apb(1'b0, 12'h01C, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, 12'h00C, 32'h0000_0027);
        rdc("narrow reserved", 12'h00C, 32'h0000_0007);
        apb(1'b1, 12'h010, 32'h0000_002F);
        rdc("wide reserved", 12'h010, 32'h0000_0028);
        $display("test regs done");
    endtask : test_regs

    task automatic test_events();
        apb(1'b1, 12'h00C, 32'h0000_0040);
        apb(1'b1, 12'h000, 32'h0000_0000);
        apb(1'b1, 12'h00C, 32'h0000_0050);
        ptc_event_src_inst.pulse(0, 5);
        rdc("pin rising", 12'h000, 32'h0000_0005);
        apb(1'b1, 12'h00C, 32'h0000_0058);
        ptc_event_src_inst.pulse(0, 3);
        rdc("pin falling", 12'h000, 32'h0000_0008);
        apb(1'b1, 12'h00C, 32'h0000_0018);
        ptc_event_src_inst.pulse(2, 4);
        rdc("comparator", 12'h000, 32'h0000_000C);
        apb(1'b1, 12'h00C, 32'h0000_00D8);
        ptc_event_src_inst.pulse(0, 1);
        rdc("pulse run clear", 12'h00C, 32'h0000_00C8);
        $display("test events done");
    endtask : test_events

    task automatic test_timer();
        int first;
        apb(1'b1, 12'h00C, 32'h0000_0087);
        apb(1'b1, 12'h000, 32'h0000_00FE);
        rdc("stopped preload", 12'h000, 32'h0000_00FE);
        apb(1'b1, 12'h014, 32'h0000_0001);
        apb(1'b1, 12'h00C, 32'h0000_0097);
        wait_irq(n_irq + 1);
        first = last_irq;
        rdc("reload", 12'h000, 32'h0000_00FE);
        apb(1'b1, 12'h000, 32'h0000_0010);
        rdc("running preload", 12'h000, 32'h0000_00FE);
        wait_irq(n_irq + 1);
        chk("prescaled period", last_irq - first, 32'd256);
        rdc("new reload", 12'h000, 32'h0000_0010);
        apb(1'b1, 12'h00C, 32'h0000_0007);
        apb(1'b1, 12'h014, 32'h0000_0000);
        $display("test timer done");
    endtask : test_timer

    task automatic test_wide();
        apb(1'b1, 12'h010, 32'h0000_0040);
        apb(1'b1, 12'h004, 32'h0000_0034);
        rdc("high before", 12'h008, 32'h0000_0000);
        rdc("low staged only", 12'h004, 32'h0000_0000);
        apb(1'b1, 12'h008, 32'h0000_0012);
        rdc("high load", 12'h008, 32'h0000_0012);
        rdc("low moved", 12'h004, 32'h0000_0034);
        apb(1'b1, 12'h010, 32'h0000_0050);
        ptc_event_src_inst.pulse(1, 3);
        rdc("wide high", 12'h008, 32'h0000_0012);
        rdc("wide low latch", 12'h004, 32'h0000_0037);
        apb(1'b1, 12'h010, 32'h0000_0040);
        apb(1'b1, 12'h004, 32'h0000_00FF);
        apb(1'b1, 12'h008, 32'h0000_00FF);
        apb(1'b1, 12'h010, 32'h0000_0050);
        ptc_event_src_inst.pulse(1, 1);
        chk("masked irq", w_irq, 32'd0);
        rdc("wide reload high", 12'h008, 32'h0000_00FF);
        apb(1'b1, 12'h014, 32'h0000_0002);
        power_down <= 1'b1;
        ptc_event_src_inst.pulse(1, 1);
        chk("wide irq", w_irq, 32'd1);
        chk("wake", n_wake, 32'd1);
        power_down <= 1'b0;
        $display("test wide done");
    endtask : test_wide

    task automatic test_wide_src();
        int first;
        apb(1'b1, 12'h010, 32'h0000_0008);
        apb(1'b1, 12'h004, 32'h0000_00F0);
        apb(1'b1, 12'h008, 32'h0000_00FF);
        apb(1'b1, 12'h010, 32'h0000_0018);
        ptc_event_src_inst.pulse(3, 2);
        rdc("wide cmp high", 12'h008, 32'h0000_00FF);
        rdc("wide cmp low", 12'h004, 32'h0000_00F2);
        apb(1'b1, 12'h010, 32'h0000_00B0);
        ptc_event_src_inst.pulse(4, 3);
        apb(1'b1, 12'h010, 32'h0000_00A0);
        rdc("sub high", 12'h008, 32'h0000_00FF);
        rdc("sub low", 12'h004, 32'h0000_00F5);
        apb(1'b1, 12'h010, 32'h0000_0090);
        wait_wide(w_irq + 1);
        first = w_last;
        wait_wide(w_irq + 1);
        chk("quarter period", w_last - first, 32'd64);
        apb(1'b1, 12'h010, 32'h0000_0008);
        $display("test wide src done");
    endtask : test_wide_src

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_regs();
        test_events();
        test_timer();
        test_wide();
        test_wide_src();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        report_and_stop();
    end
endmodule : tb_top
